// ---- common/rtcbk_defines.svh ----
// Register offsets, field positions, reset values and counts of the clock
`ifndef RTCBK_DEFINES_SVH
`define RTCBK_DEFINES_SVH

`define RTCBK_OFS_TIME 8'h00
`define RTCBK_OFS_DATE 8'h04
`define RTCBK_OFS_CTRL 8'h08
`define RTCBK_OFS_STAT 8'h0C
`define RTCBK_OFS_PRER 8'h10
`define RTCBK_OFS_WUTR 8'h14
`define RTCBK_OFS_ALRA 8'h18
`define RTCBK_OFS_ALRB 8'h1C
`define RTCBK_OFS_SSR 8'h20
`define RTCBK_OFS_ALRASS 8'h24
`define RTCBK_OFS_ALRBSS 8'h28
`define RTCBK_BKP_IDX0 6'h14
`define RTCBK_BKP_WORDS 20

`define RTCBK_CTRL_W 17
`define RTCBK_C_FMT12 0
`define RTCBK_C_ALRAE 1
`define RTCBK_C_ALRBE 2
`define RTCBK_C_WUE 3
`define RTCBK_C_ALRAIE 4
`define RTCBK_C_ALRBIE 5
`define RTCBK_C_WUIE 6
`define RTCBK_C_CALOE 7
`define RTCBK_C_REFE 8
`define RTCBK_C_REF60 9
`define RTCBK_C_CKSEL 11:10
`define RTCBK_C_WUSEL 14:12
`define RTCBK_C_TAMPIE 15
`define RTCBK_C_TSIE 16

`define RTCBK_ASYNC_RST 7'h7F
`define RTCBK_SYNC_RST 13'h0FF
`define RTCBK_FAST_TOP 7'h7F
`define RTCBK_REF50_TOP 6'h31
`define RTCBK_REF60_TOP 6'h3B
`define RTCBK_CAL_BIT 5

`endif

// ---- common/rtcbk_pkg.sv ----
// Types shared by the calendar clock modules
`default_nettype none
package rtcbk_pkg;
  typedef enum logic [1:0] {
    RTCBK_CK_LSE = 2'h0,
    RTCBK_CK_LSI = 2'h1,
    RTCBK_CK_FAST = 2'h2
  } rtcbk_clk_e;

  typedef struct packed {
    logic pm;
    logic [5:0] hour;
    logic [6:0] min;
    logic [6:0] sec;
    logic [2:0] wday;
    logic [7:0] year;
    logic [4:0] month;
    logic [5:0] date;
  } rtcbk_cal_s;
endpackage : rtcbk_pkg
`default_nettype wire

// ---- common/rtcbk_cal_if.sv ----
// Link between the bus side and the calendar keeper
`default_nettype none
interface rtcbk_cal_if;
  import rtcbk_pkg::*;
  logic secTick;
  logic wrTime;
  logic wrDate;
  logic fmt12;
  logic [31:0] wrData;
  rtcbk_cal_s cal;
  modport ctl (output secTick, wrTime, wrDate, fmt12, wrData, input cal);
  modport keep (input secTick, wrTime, wrDate, fmt12, wrData, output cal);
endinterface : rtcbk_cal_if
`default_nettype wire

// ---- src/rtcbk_wakeup.sv ----
// Auto-reload binary downcounter giving one pulse per expiry
`default_nettype none
module rtcbk_wakeup #(
  parameter int unsigned WIDTH = 16
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic en,
  input wire logic resTick,
  input wire logic [WIDTH-1:0] reload,
  output logic expire
);
  logic [WIDTH-1:0] cnt_r, cnt_nxt;
  logic expire_r, expire_nxt;

  always_comb begin
    cnt_nxt = cnt_r;
    expire_nxt = 1'b0;
    if (!en) begin
      // Idle counter tracks the reload so enabling starts a full period
      cnt_nxt = reload;
    end else if (resTick) begin
      if (cnt_r == '0) begin
        cnt_nxt = reload; // RL19
        expire_nxt = 1'b1; // RL9
      end else begin
        cnt_nxt = cnt_r - 1'b1; // RL9
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r <= '0;
      expire_r <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      expire_r <= expire_nxt;
    end
  end

  assign expire = expire_r;
endmodule : rtcbk_wakeup
`default_nettype wire

// ---- src/rtcbk_calendar.sv ----
// BCD time and date keeper with month length and 12/24 hour handling
`default_nettype none
module rtcbk_calendar (
  input wire logic clk,
  input wire logic rst_n,
  rtcbk_cal_if.keep bus
);
  import rtcbk_pkg::*;

  rtcbk_cal_s cal_r, cal_nxt;

  function automatic logic [7:0] rtcbk_bcd_inc(input logic [7:0] v);
    if (v[3:0] != 4'h9) return {v[7:4], v[3:0] + 4'h1};
    return (v[7:4] == 4'h9) ? 8'h00 : {v[7:4] + 4'h1, 4'h0}; // RL1
  endfunction : rtcbk_bcd_inc

  function automatic logic [5:0] rtcbk_dim(input logic [4:0] m,
      input logic [7:0] y);
    logic leap;
    // Every fourth year; century years are not special-cased
    leap = y[4] ? (y[3:0] == 4'h2 || y[3:0] == 4'h6)
                : (y[3:0] == 4'h0 || y[3:0] == 4'h4 || y[3:0] == 4'h8);
    if (m == 5'h02) return leap ? 6'h29 : 6'h28;
    if (m == 5'h04 || m == 5'h06 || m == 5'h09 || m == 5'h11) return 6'h30;
    return 6'h31;
  endfunction : rtcbk_dim

  always_comb begin
    logic dayRoll;
    dayRoll = 1'b0;
    cal_nxt = cal_r;
    if (bus.wrTime) begin
      cal_nxt.sec = bus.wrData[6:0];
      cal_nxt.min = bus.wrData[14:8];
      cal_nxt.hour = bus.wrData[21:16];
      cal_nxt.pm = bus.wrData[22] & bus.fmt12;
    end else if (bus.wrDate) begin
      cal_nxt.date = bus.wrData[5:0];
      cal_nxt.month = bus.wrData[12:8];
      cal_nxt.wday = bus.wrData[15:13];
      cal_nxt.year = bus.wrData[23:16];
    end else if (bus.secTick) begin
      if (cal_r.sec != 7'h59) begin
        cal_nxt.sec = 7'(rtcbk_bcd_inc({1'b0, cal_r.sec})); // RL1
      end else begin
        cal_nxt.sec = 7'h00;
        if (cal_r.min != 7'h59) begin
          cal_nxt.min = 7'(rtcbk_bcd_inc({1'b0, cal_r.min}));
        end else begin
          cal_nxt.min = 7'h00;
          if (bus.fmt12) begin
            if (cal_r.hour == 6'h12) cal_nxt.hour = 6'h01; // RL1
            else cal_nxt.hour = 6'(rtcbk_bcd_inc({2'h0, cal_r.hour}));
            if (cal_r.hour == 6'h11) begin
              cal_nxt.pm = ~cal_r.pm;
              dayRoll = cal_r.pm;
            end
          end else if (cal_r.hour == 6'h23) begin
            cal_nxt.hour = 6'h00; // RL1
            dayRoll = 1'b1;
          end else begin
            cal_nxt.hour = 6'(rtcbk_bcd_inc({2'h0, cal_r.hour}));
          end
        end
      end
      if (dayRoll) begin
        cal_nxt.wday = (cal_r.wday == 3'h7) ? 3'h1 : cal_r.wday + 3'h1;
        if (cal_r.date == rtcbk_dim(cal_r.month, cal_r.year)) begin
          cal_nxt.date = 6'h01; // RL2
          if (cal_r.month == 5'h12) begin
            cal_nxt.month = 5'h01;
            cal_nxt.year = rtcbk_bcd_inc(cal_r.year);
          end else begin
            cal_nxt.month = 5'(rtcbk_bcd_inc({3'h0, cal_r.month}));
          end
        end else begin
          cal_nxt.date = 6'(rtcbk_bcd_inc({2'h0, cal_r.date}));
        end
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cal_r <= '{pm: 1'b0, hour: 6'h00, min: 7'h00, sec: 7'h00,
                 wday: 3'h1, year: 8'h00, month: 5'h01, date: 6'h01};
    end else begin
      cal_r <= cal_nxt;
    end
  end

  assign bus.cal = cal_r;
endmodule : rtcbk_calendar
`default_nettype wire

// ---- src/rtcbk_top.sv ----
// Calendar clock top: bus slave, time base, alarms, events, backup words
//
// Added by the designer: the register addresses and the APB interface to the registers.
`include "rtcbk_defines.svh"
`default_nettype none

// Overview of operation
// RL1 - Seconds through year kept in BCD; hours in 12 or 24 hour format
// RL2 - Date rolls over after 28, 29, 30 or 31 days automatically
// RL3 - Optional 50 or 60 Hz reference paces the seconds instead
// RL4 - Alarm and periodic wakeup can wake the chip from Stop and Standby
// RL5 - Sub-second count readable in plain binary
// RL6 - Kernel tick from crystal, low-speed RC or fast clock over 128
// RL7 - A 512 Hz calibration signal can drive an output pin
// RL8 - Two alarm comparators, every field individually maskable
// RL9 - 16-bit auto-reload wakeup downcounter with selectable resolution
// RL10 - 20-bit prescaler; reset setting gives 1 Hz from 32.768 kHz
// RL11 - Twenty 32-bit backup words, 80 bytes of user data
// RL12 - Backup words not cleared by system reset or Standby wake; here rst_n, which resets every other register, clears them too
// RL13 - Alarm registers hold sub-second through date match values
// RL14 - Alarm, wakeup, tamper and timestamp events drive interrupt lines
// RL15 - Those events request exit from Standby
// RL16 - Backup-domain contents survive Standby
// RL17 - No event ends battery-only operation
// RL18 - Sticky flag per alarm and wakeup; interrupt when enabled
// RL19 - Wakeup counter reloads after zero and keeps counting while enabled
module rtcbk_top #(
  parameter int unsigned BKP_WORDS = `RTCBK_BKP_WORDS
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic lseClk,
  input wire logic lsiClk,
  input wire logic highSpeedExternalClock,
  input wire logic refClk,
  input wire logic tamperIn,
  input wire logic tstampIn,
  input wire logic vbatMode,
  output logic calOut,
  output logic [3:0] externalInterruptLine,
  output logic wakeStandby
);
  import rtcbk_pkg::*;

  localparam int unsigned BW = $clog2(BKP_WORDS);

  rtcbk_cal_if calBus ();

  logic [`RTCBK_CTRL_W-1:0] ctrl_r, ctrl_nxt;
  logic [6:0] asyncPre_r, asyncPre_nxt;
  logic [12:0] syncPre_r, syncPre_nxt;
  logic [15:0] wuRel_r, wuRel_nxt;
  logic [31:0] alrA_r, alrA_nxt, alrB_r, alrB_nxt;
  logic [13:0] ssA_r, ssA_nxt, ssB_r, ssB_nxt;
  logic [31:0] prdata_r, prdata_nxt, rdMux;
  logic pslverr_r, pslverr_nxt, errAddr;
  logic [31:0] bkp_r [BKP_WORDS];

  logic [5:0] inNow, inPrev_r, edges;
  logic [6:0] fastDiv_r, fastDiv_nxt, asyncCnt_r, asyncCnt_nxt;
  logic [12:0] syncCnt_r, syncCnt_nxt;
  logic [5:0] refCnt_r, refCnt_nxt;
  logic [3:0] wuDiv_r, wuDiv_nxt;
  logic calOut_r, calOut_nxt;
  logic kTick, ckSpre, presSec, refSec, secTick, resTick, wuExp;

  logic [4:0] stat_r, stat_nxt, evSet, evClr;
  logic [1:0] hitPrev_r, hitPrev_nxt;
  logic alrAHit, alrBHit;
  logic [3:0] line_r, line_nxt;
  logic wake_r, wake_nxt;

  logic setup, wrOk, bkpHit, prerWr;
  logic [5:0] wordIdx;
  logic [BW-1:0] bkpIdx;
  logic fmt12, aEn, bEn, wuEn, aIe, bIe, wuIe, calEn, refEn, ref60;
  logic tampIe, tsIe;
  logic [2:0] wuSel;
  rtcbk_clk_e clkSel;

  function automatic logic rtcbk_alr_hit(input logic [31:0] a,
      input logic [13:0] s, input rtcbk_cal_s c, input logic [12:0] ss);
    logic dayOk;
    dayOk = a[30] ? (a[26:24] == c.wday) : (a[29:24] == c.date);
    return (a[7] | (a[6:0] == c.sec)) & (a[15] | (a[14:8] == c.min))
      & (a[23] | (a[22:16] == {c.pm, c.hour})) & (a[31] | dayOk)
      & (s[13] | (s[12:0] == ss));
  endfunction : rtcbk_alr_hit

  assign fmt12 = ctrl_r[`RTCBK_C_FMT12];
  assign aEn = ctrl_r[`RTCBK_C_ALRAE];
  assign bEn = ctrl_r[`RTCBK_C_ALRBE];
  assign wuEn = ctrl_r[`RTCBK_C_WUE];
  assign aIe = ctrl_r[`RTCBK_C_ALRAIE];
  assign bIe = ctrl_r[`RTCBK_C_ALRBIE];
  assign wuIe = ctrl_r[`RTCBK_C_WUIE];
  assign calEn = ctrl_r[`RTCBK_C_CALOE];
  assign refEn = ctrl_r[`RTCBK_C_REFE];
  assign ref60 = ctrl_r[`RTCBK_C_REF60];
  assign clkSel = rtcbk_clk_e'(ctrl_r[`RTCBK_C_CKSEL]);
  assign wuSel = ctrl_r[`RTCBK_C_WUSEL];
  assign tampIe = ctrl_r[`RTCBK_C_TAMPIE];
  assign tsIe = ctrl_r[`RTCBK_C_TSIE];

  // Bus decode; every access completes without wait states
  assign setup = psel & ~penable;
  assign wrOk = psel & penable & pwrite & ~pslverr_r;
  assign pready = 1'b1;
  assign wordIdx = paddr[7:2];
  assign bkpHit = (paddr[1:0] == 2'h0) && (wordIdx >= `RTCBK_BKP_IDX0)
    && (wordIdx < 6'(`RTCBK_BKP_IDX0 + BKP_WORDS));
  assign bkpIdx = BW'(wordIdx - `RTCBK_BKP_IDX0);
  assign prerWr = wrOk && (paddr == `RTCBK_OFS_PRER);

  assign calBus.secTick = secTick;
  assign calBus.fmt12 = fmt12;
  assign calBus.wrData = pwdata;
  assign calBus.wrTime = wrOk && (paddr == `RTCBK_OFS_TIME);
  assign calBus.wrDate = wrOk && (paddr == `RTCBK_OFS_DATE);

  always_comb begin
    rdMux = 32'h0000_0000;
    errAddr = 1'b0;
    case (paddr)
      `RTCBK_OFS_TIME: rdMux = {9'h000, calBus.cal.pm, calBus.cal.hour,
        1'h0, calBus.cal.min, 1'h0, calBus.cal.sec}; // RL1
      `RTCBK_OFS_DATE: rdMux = {8'h00, calBus.cal.year, calBus.cal.wday,
        calBus.cal.month, 2'h0, calBus.cal.date};
      `RTCBK_OFS_CTRL: rdMux = 32'(ctrl_r);
      `RTCBK_OFS_STAT: rdMux = 32'(stat_r);
      `RTCBK_OFS_PRER: rdMux = {9'h000, asyncPre_r, 3'h0, syncPre_r};
      `RTCBK_OFS_WUTR: rdMux = {16'h0000, wuRel_r};
      `RTCBK_OFS_ALRA: rdMux = alrA_r;
      `RTCBK_OFS_ALRB: rdMux = alrB_r;
      `RTCBK_OFS_SSR: rdMux = {19'h00000, syncCnt_r}; // RL5
      `RTCBK_OFS_ALRASS: rdMux = {ssA_r[13], 18'h00000, ssA_r[12:0]};
      `RTCBK_OFS_ALRBSS: rdMux = {ssB_r[13], 18'h00000, ssB_r[12:0]};
      default: begin
        if (bkpHit) rdMux = bkp_r[bkpIdx];
        else errAddr = 1'b1;
      end
    endcase
  end

  // Configuration registers
  always_comb begin
    ctrl_nxt = ctrl_r;
    asyncPre_nxt = asyncPre_r;
    syncPre_nxt = syncPre_r;
    wuRel_nxt = wuRel_r;
    alrA_nxt = alrA_r;
    alrB_nxt = alrB_r;
    ssA_nxt = ssA_r;
    ssB_nxt = ssB_r;
    prdata_nxt = prdata_r;
    pslverr_nxt = pslverr_r;
    if (setup) begin
      prdata_nxt = rdMux;
      pslverr_nxt = errAddr;
    end
    if (wrOk) begin
      case (paddr)
        `RTCBK_OFS_CTRL: ctrl_nxt = pwdata[`RTCBK_CTRL_W-1:0];
        `RTCBK_OFS_PRER: begin
          asyncPre_nxt = pwdata[22:16]; // RL10
          syncPre_nxt = pwdata[12:0];
        end
        `RTCBK_OFS_WUTR: wuRel_nxt = pwdata[15:0];
        `RTCBK_OFS_ALRA: alrA_nxt = pwdata; // RL13
        `RTCBK_OFS_ALRB: alrB_nxt = pwdata;
        `RTCBK_OFS_ALRASS: ssA_nxt = {pwdata[31], pwdata[12:0]};
        `RTCBK_OFS_ALRBSS: ssB_nxt = {pwdata[31], pwdata[12:0]};
        default: ;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_r <= '0;
      asyncPre_r <= `RTCBK_ASYNC_RST; // RL10
      syncPre_r <= `RTCBK_SYNC_RST;
      wuRel_r <= 16'hFFFF;
      alrA_r <= 32'h0000_0000;
      alrB_r <= 32'h0000_0000;
      ssA_r <= 14'h2000;
      ssB_r <= 14'h2000;
      prdata_r <= 32'h0000_0000;
      pslverr_r <= 1'b0;
    end else begin
      ctrl_r <= ctrl_nxt;
      asyncPre_r <= asyncPre_nxt;
      syncPre_r <= syncPre_nxt;
      wuRel_r <= wuRel_nxt;
      alrA_r <= alrA_nxt;
      alrB_r <= alrB_nxt;
      ssA_r <= ssA_nxt;
      ssB_r <= ssB_nxt;
      prdata_r <= prdata_nxt;
      pslverr_r <= pslverr_nxt;
    end
  end

  // The same rst_n that resets every other register also clears these
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < int'(BKP_WORDS); i++) bkp_r[i] <= '0; // RL12 RL16
    end else if (wrOk && bkpHit) begin
      bkp_r[bkpIdx] <= pwdata; // RL11
    end
  end

  // Time base
  assign inNow = {tstampIn, tamperIn, refClk, highSpeedExternalClock,
                  lsiClk, lseClk};
  assign edges = inNow & ~inPrev_r;

  always_comb begin
    fastDiv_nxt = edges[2] ? fastDiv_r + 7'h01 : fastDiv_r;
    unique case (clkSel)
      RTCBK_CK_LSE: kTick = edges[0]; // RL6
      RTCBK_CK_LSI: kTick = edges[1];
      RTCBK_CK_FAST: kTick = edges[2] && (fastDiv_r == `RTCBK_FAST_TOP);
      default: kTick = 1'b0;
    endcase
    ckSpre = 1'b0;
    presSec = 1'b0;
    refSec = 1'b0;
    asyncCnt_nxt = asyncCnt_r;
    syncCnt_nxt = syncCnt_r;
    refCnt_nxt = refCnt_r;
    if (prerWr) begin
      asyncCnt_nxt = pwdata[22:16];
      syncCnt_nxt = pwdata[12:0];
    end else if (kTick) begin
      if (asyncCnt_r == 7'h00) begin
        asyncCnt_nxt = asyncPre_r; // RL10
        ckSpre = 1'b1;
      end else begin
        asyncCnt_nxt = asyncCnt_r - 7'h01;
      end
    end
    if (ckSpre) begin
      if (syncCnt_r == 13'h0000) begin
        syncCnt_nxt = syncPre_r;
        presSec = 1'b1;
      end else begin
        syncCnt_nxt = syncCnt_r - 13'h0001;
      end
    end
    // Reference seconds realign the sub-second phase each time
    if (refEn && edges[3]) begin
      if (refCnt_r >= (ref60 ? `RTCBK_REF60_TOP : `RTCBK_REF50_TOP)) begin
        refCnt_nxt = 6'h00; // RL3
        refSec = 1'b1;
        syncCnt_nxt = syncPre_r;
      end else begin
        refCnt_nxt = refCnt_r + 6'h01;
      end
    end
    secTick = refEn ? refSec : presSec; // RL3
    wuDiv_nxt = kTick ? wuDiv_r + 4'h1 : wuDiv_r;
    case (wuSel)
      3'h0: resTick = kTick && (wuDiv_r == 4'hF); // RL9
      3'h1: resTick = kTick && (wuDiv_r[2:0] == 3'h7);
      3'h2: resTick = kTick && (wuDiv_r[1:0] == 2'h3);
      3'h3: resTick = kTick && wuDiv_r[0];
      default: resTick = secTick;
    endcase
    calOut_nxt = calEn & asyncCnt_r[`RTCBK_CAL_BIT]; // RL7
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      inPrev_r <= 6'h00;
      fastDiv_r <= 7'h00;
      asyncCnt_r <= `RTCBK_ASYNC_RST;
      syncCnt_r <= `RTCBK_SYNC_RST;
      refCnt_r <= 6'h00;
      wuDiv_r <= 4'h0;
      calOut_r <= 1'b0;
    end else begin
      inPrev_r <= inNow;
      fastDiv_r <= fastDiv_nxt;
      asyncCnt_r <= asyncCnt_nxt;
      syncCnt_r <= syncCnt_nxt;
      refCnt_r <= refCnt_nxt;
      wuDiv_r <= wuDiv_nxt;
      calOut_r <= calOut_nxt;
    end
  end

  rtcbk_calendar calKeeper (
    .clk(sys_clk),
    .rst_n(rst_n),
    .bus(calBus)
  );

  rtcbk_wakeup #(
    .WIDTH(16)
  ) wakeTimer (
    .clk(sys_clk),
    .rst_n(rst_n),
    .en(wuEn),
    .resTick(resTick),
    .reload(wuRel_r),
    .expire(wuExp)
  );

  // Events, sticky flags and wake requests
  always_comb begin
    alrAHit = aEn & rtcbk_alr_hit(alrA_r, ssA_r, calBus.cal, syncCnt_r);
    alrBHit = bEn & rtcbk_alr_hit(alrB_r, ssB_r, calBus.cal, syncCnt_r);
    hitPrev_nxt = {alrBHit, alrAHit};
    evSet = {edges[5], edges[4], wuExp,
             alrBHit & ~hitPrev_r[1], alrAHit & ~hitPrev_r[0]}; // RL8
    evClr = (wrOk && paddr == `RTCBK_OFS_STAT) ? pwdata[4:0] : 5'h00;
    // A new event in the clearing cycle survives
    stat_nxt = (stat_r & ~evClr) | evSet; // RL18
    line_nxt = {stat_r[4] & tsIe, stat_r[3] & tampIe, stat_r[2] & wuIe,
                (stat_r[0] & aIe) | (stat_r[1] & bIe)}; // RL14 RL4
    wake_nxt = (|line_nxt) & ~vbatMode; // RL15 RL17
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      stat_r <= 5'h00;
      hitPrev_r <= 2'h0;
      line_r <= 4'h0;
      wake_r <= 1'b0;
    end else begin
      stat_r <= stat_nxt;
      hitPrev_r <= hitPrev_nxt;
      line_r <= line_nxt;
      wake_r <= wake_nxt;
    end
  end

  assign prdata = prdata_r;
  assign pslverr = pslverr_r;
  assign calOut = calOut_r;
  assign externalInterruptLine = line_r;
  assign wakeStandby = wake_r;
endmodule : rtcbk_top
`default_nettype wire

// ---- tb/rtcbk_chk.sv ----
// Port-level assertions for the calendar clock top
`default_nettype none
module rtcbk_chk (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic tamperIn,
  input wire logic vbatMode,
  input wire logic calOut,
  input wire logic [3:0] externalInterruptLine,
  input wire logic wakeStandby
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] ctrlSh_r;
  logic [3:0] ienV;
  logic setup;
  function automatic logic okAddr(input logic [7:0] a);
    return a[1:0] == 2'h0 && (a <= 8'h28 || (a >= 8'h50 && a <= 8'h9C));
  endfunction : okAddr
  assign setup = psel && !penable;
  assign ienV = {ctrlSh_r[16], ctrlSh_r[15], ctrlSh_r[6],
                 ctrlSh_r[5] | ctrlSh_r[4]};
  // Shadow of the control word so enables can be judged from the ports
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrlSh_r <= 32'h0;
    end else if (psel && penable && pwrite && paddr == 8'h08) begin
      ctrlSh_r <= pwdata;
    end
  end
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);
  property p_rdy;
    pready;
  endproperty
  a_rdy: assert property (p_rdy) else $error("pready low");
  property p_err;
    setup && !okAddr(paddr) |=> pslverr && prdata == 32'h0;
  endproperty
  a_err: assert property (p_err) else $error("no error");
  property p_ok;
    setup && okAddr(paddr) |=> !pslverr;
  endproperty
  a_ok: assert property (p_ok) else $error("false error");
  property p_hold;
    !setup |=> $stable(prdata) && $stable(pslverr);
  endproperty
  a_hold: assert property (p_hold) else $error("read data moved");
  property p_wake_vbat;
    vbatMode && $past(vbatMode) |-> !wakeStandby;
  endproperty
  a_wake_vbat: assert property (p_wake_vbat)
    else $error("wake on battery");
  property p_wake_or;
    !$past(vbatMode) |-> wakeStandby == (|externalInterruptLine);
  endproperty
  a_wake_or: assert property (p_wake_or) else $error("wake mismatch");
  property p_line_off;
    (externalInterruptLine & ~$past(ienV)) == 4'h0;
  endproperty
  a_line_off: assert property (p_line_off) else $error("bad line");
  property p_cal_off;
    !$past(ctrlSh_r[7]) |-> !calOut;
  endproperty
  a_cal_off: assert property (p_cal_off) else $error("cal out on");
  property p_tamp_rise;
    $rose(tamperIn) && ctrlSh_r[15] |-> ##[1:6] externalInterruptLine[2];
  endproperty
  a_tamp_rise: assert property (p_tamp_rise) else $error("no tamper");
  c_wu: cover property ($rose(externalInterruptLine[1]));
  c_vbat: cover property (vbatMode && |externalInterruptLine);
  c_err: cover property (setup && !okAddr(paddr));
endmodule : rtcbk_chk
bind rtcbk_top rtcbk_chk u_rtcbk_chk (.sys_clk(sys_clk), .rst_n(rst_n),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .tamperIn(tamperIn), .vbatMode(vbatMode), .calOut(calOut),
  .externalInterruptLine(externalInterruptLine),
  .wakeStandby(wakeStandby));
`default_nettype wire

// ---- tb/rtcbk_osc_model.sv ----
// Free-running kernel and reference sources as sampled levels
`default_nettype none
module rtcbk_osc_model (
  input wire logic sys_clk,
  input wire logic rst_n,
  output logic lseClk,
  output logic lsiClk,
  output logic highSpeedExternalClock,
  output logic refClk
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] cnt_r;
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r <= 3'h0;
    end else begin
      cnt_r <= cnt_r + 3'h1;
    end
  end
  // One crystal edge per two cycles keeps a test second short
  assign lseClk = cnt_r[0];
  assign highSpeedExternalClock = cnt_r[0];
  assign lsiClk = cnt_r[1];
  assign refClk = cnt_r[2];
endmodule : rtcbk_osc_model
`default_nettype wire

// ---- tb/rtcbk_top_tb.sv ----
// Self-checking bench for the calendar clock top
`default_nettype none
module rtcbk_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    logic [7:0] a;
    logic w;
    logic [31:0] d;
    logic e;
  } rtcbk_row_s;
  localparam logic [31:0] STOP = 32'h00000C00;
  localparam rtcbk_row_s ROWS [16] = '{
    '{8'h00, 1'b0, 32'h0, 1'b0}, '{8'h04, 1'b0, 32'h00002101, 1'b0},
    '{8'h08, 1'b0, 32'h0, 1'b0}, '{8'h0C, 1'b0, 32'h0, 1'b0},
    '{8'h10, 1'b0, 32'h007F00FF, 1'b0}, '{8'h14, 1'b0, 32'hFFFF, 1'b0},
    '{8'h18, 1'b0, 32'h0, 1'b0}, '{8'h24, 1'b0, 32'h80000000, 1'b0},
    '{8'h50, 1'b1, 32'hA5A50001, 1'b0}, '{8'h9C, 1'b1, 32'h5A5A0013, 1'b0},
    '{8'h50, 1'b0, 32'hA5A50001, 1'b0}, '{8'h9C, 1'b0, 32'h5A5A0013, 1'b0},
    '{8'h2C, 1'b1, 32'h1234, 1'b1}, '{8'h2C, 1'b0, 32'h0, 1'b1},
    '{8'h02, 1'b0, 32'h0, 1'b1}, '{8'hA0, 1'b0, 32'h0, 1'b1}};
  // Time, date, run control, expected date, expected hour and minute
  localparam logic [31:0] CAL [6][5] = '{
    '{32'h235959, 32'h012228, 32'h0, 32'h014301, 32'h0},
    '{32'h235959, 32'h042228, 32'h0, 32'h044229, 32'h0},
    '{32'h235959, 32'h01E430, 32'h0, 32'h012501, 32'h0},
    '{32'h235959, 32'h012130, 32'h0, 32'h014131, 32'h0},
    '{32'h235959, 32'h993231, 32'h0, 32'h004101, 32'h0},
    '{32'h115959, 32'h012201, 32'h1, 32'h012201, 32'h520000}};
  localparam logic [31:0] EV [4] = '{32'hC12, 32'hC24, 32'h8C00, 32'h10C00};
  localparam logic [31:0] SB [4] = '{32'h1, 32'h2, 32'h8, 32'h10};
  localparam int LI [4] = '{0, 0, 2, 3};
  logic sys_clk, rst_n, psel, penable, pwrite, pready, pslverr, e;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic lseClk, lsiClk, highSpeedExternalClock, refClk;
  logic tamperIn, tstampIn, vbatMode, calOut, wakeStandby;
  logic [3:0] externalInterruptLine;
  int errors, total_checks, n, na, nb;
  rtcbk_osc_model u_rtcbk_osc_model (.sys_clk(sys_clk), .rst_n(rst_n),
    .lseClk(lseClk), .lsiClk(lsiClk), .refClk(refClk),
    .highSpeedExternalClock(highSpeedExternalClock));
  rtcbk_top u_rtcbk_top (.sys_clk(sys_clk), .rst_n(rst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .lseClk(lseClk),
    .lsiClk(lsiClk), .highSpeedExternalClock(highSpeedExternalClock),
    .refClk(refClk), .tamperIn(tamperIn), .tstampIn(tstampIn),
    .vbatMode(vbatMode), .calOut(calOut), .wakeStandby(wakeStandby),
    .externalInterruptLine(externalInterruptLine));
  always #4 sys_clk = ~sys_clk;
  task automatic chk(input string s, input logic [31:0] x,
      input logic [31:0] g);
    total_checks++;
    if (g !== x) begin
      errors++;
      $display("BAD %s expected %h seen %h", s, x, g);
    end
  endtask : chk
  // Idle cycle after each transfer avoids double drives between calls
  task automatic apb(input logic w, input logic [7:0] a,
      input logic [31:0] d);
    int k;
    k = 0;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    @(posedge sys_clk);
    while (pready !== 1'b1 && k < 20) begin
      k++;
      @(posedge sys_clk);
    end
    if (k == 20) errors++;
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge sys_clk);
  endtask : apb
  task automatic waitLine(input int i, input logic v, output int c);
    c = 0;
    @(negedge sys_clk);
    while (externalInterruptLine[i] !== v && c < 200) begin
      c++;
      @(negedge sys_clk);
    end
    if (c == 200) errors++;
    @(posedge sys_clk);
  endtask : waitLine
  task automatic give_verdict;
    $display("Checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : give_verdict
  initial begin
    #40000;
    errors++;
    give_verdict();
  end
  initial begin
    {sys_clk, rst_n, psel, penable, pwrite, paddr, pwdata} = '0;
    {tamperIn, tstampIn, vbatMode, errors, total_checks} = '0;
    repeat (3) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(posedge sys_clk);
    foreach (ROWS[k]) begin
      apb(ROWS[k].w, ROWS[k].a, ROWS[k].d);
      if (!ROWS[k].w) chk("rdata", ROWS[k].d, q);
      chk("slverr", {31'h0, ROWS[k].e}, {31'h0, e});
    end
    for (int k = 0; k < 6; k++) begin
      apb(1'b1, 8'h08, STOP);
      apb(1'b1, 8'h10, 32'h00010001);
      apb(1'b1, 8'h00, CAL[k][0]);
      apb(1'b1, 8'h04, CAL[k][1]);
      apb(1'b1, 8'h08, CAL[k][2]);
      repeat (10) @(posedge sys_clk);
      apb(1'b1, 8'h08, STOP);
      apb(1'b0, 8'h04, 32'h0);
      chk("date", CAL[k][3], q);
      apb(1'b0, 8'h00, 32'h0);
      chk("hourMin", CAL[k][4], q & 32'h007F7F00);
    end
    apb(1'b1, 8'h14, 32'h2);
    apb(1'b1, 8'h0C, 32'h1F);
    apb(1'b1, 8'h08, 32'h3048);
    waitLine(1, 1'b1, n);
    apb(1'b1, 8'h0C, 32'h4);
    waitLine(1, 1'b0, na);
    waitLine(1, 1'b1, nb);
    chk("wuPeriod", 32'd12, 32'(5 + na + nb));
    vbatMode <= 1'b1;
    repeat (4) @(posedge sys_clk);
    chk("wake", 32'h0, {31'h0, wakeStandby});
    apb(1'b0, 8'h0C, 32'h0);
    chk("wuFlag", 32'h4, q & 32'h4);
    vbatMode <= 1'b0;
    apb(1'b1, 8'h18, 32'h80808080);
    chk("wake", 32'h1, {31'h0, wakeStandby});
    apb(1'b1, 8'h1C, 32'h80808080);
    for (int k = 0; k < 4; k++) begin
      apb(1'b1, 8'h08, STOP);
      apb(1'b1, 8'h0C, 32'h1F);
      apb(1'b1, 8'h08, EV[k]);
      tamperIn <= (k == 2);
      tstampIn <= (k == 3);
      waitLine(LI[k], 1'b1, n);
      apb(1'b0, 8'h0C, 32'h0);
      chk("evStat", SB[k], q);
      tamperIn <= 1'b0;
      tstampIn <= 1'b0;
    end
    apb(1'b1, 8'h08, STOP);
    apb(1'b1, 8'h00, 32'h0);
    apb(1'b1, 8'h08, 32'h0D00);
    repeat (820) @(posedge sys_clk);
    apb(1'b1, 8'h08, STOP);
    apb(1'b0, 8'h00, 32'h0);
    chk("refSec", 32'h1, 32'(q == 32'h2 || q == 32'h3));
    apb(1'b1, 8'h10, 32'h007F00FF);
    apb(1'b0, 8'h20, 32'h0);
    chk("subSec", 32'hFF, q);
    apb(1'b1, 8'h08, 32'h480);
    n = 0;
    repeat (256) begin
      @(negedge sys_clk);
      if (calOut === 1'b1) n++;
    end
    @(posedge sys_clk);
    chk("calHigh", 32'h1, 32'(n > 96 && n < 160));
    give_verdict();
  end
endmodule : rtcbk_top_tb
`default_nettype wire
